// >>> verilog/rlf_pkg.sv
package rlf_pkg;

	// ----------------------------------------------------------------
	// register map (byte addresses)
	// ----------------------------------------------------------------
	localparam logic [7:0]  REG_CTRL      = 8'h00;
	localparam logic [7:0]  REG_FRAG      = 8'h04;
	localparam logic [7:0]  REG_LABEL     = 8'h08;
	localparam logic [7:0]  REG_SIG       = 8'h0c;
	localparam logic [7:0]  REG_STATUS    = 8'h10;

	localparam int          CTRL_SEQ      = 0;
	localparam int          CTRL_CRC      = 1;
	localparam int          CTRL_OMIT     = 2;
	localparam int          CTRL_ONBOARD  = 3;
	localparam int          CTRL_MAP      = 4;
	localparam int          CTRL_STRICT   = 5;
	localparam logic [5:0]  CTRL_RESET    = 6'h01;
	localparam logic [11:0] FRAG_RESET    = 12'h040;
	localparam logic [15:0] PTYPE_RESET   = 16'h0800;
	localparam logic [3:0]  LEN0_RESET    = 4'h1;
	localparam logic [3:0]  LEN0_ONBOARD  = 4'h6;
	localparam logic [3:0]  BLBL_RESET    = 4'h0;
	localparam logic [7:0]  SIG_RESET     = 8'h00;

	// ----------------------------------------------------------------
	// protocol constants
	// ----------------------------------------------------------------
	localparam logic [12:0] MAX_TOTAL     = 13'h0fff;
	localparam logic [15:0] PTYPE_SIGNAL  = 16'h0082;
	localparam logic [1:0]  LTYPE_SIGNAL  = 2'h3;
	localparam logic [31:0] CRC_POLY      = 32'h04c11db7;
	localparam logic [31:0] CRC_ONES      = 32'hffffffff;
	localparam logic [12:0] CRC_BYTES     = 13'h0004;
	localparam logic [12:0] SEQ_BYTES     = 13'h0001;
	localparam logic [12:0] PTYPE_BYTES   = 13'h0002;
	// fixed burst label sizes per access context, strict mode
	localparam logic [3:0]  BLBL_CTX0     = 4'h0;
	localparam logic [3:0]  BLBL_CTX1     = 4'h6;
	localparam logic [3:0]  BLBL_CTX2     = 4'h6;
	localparam logic [3:0]  FLBL_LEN      = 4'h0;

	typedef enum logic [2:0] {ST_IDLE, ST_PT0, ST_PT1, ST_BODY, ST_TRAIL, ST_DROP} rlf_state_t;

	typedef struct packed {
		logic [12:0] pktLen;      // label + extension headers + payload bytes
		logic [15:0] protoType;
		logic [1:0]  labelType;
		logic        isSignal;
	} rlf_hdr_t;

	typedef struct packed {
		logic        sof;
		logic        startInd;
		logic        endInd;
		logic [2:0]  fragId;
		logic        useCrc;
		logic        ptypeSupp;
		logic [1:0]  labelType;
		logic [12:0] fragLen;
		logic [12:0] totalLen;
	} rlf_info_t;

endpackage

// >>> verilog/rlf_fragmenter.sv
`timescale 1ns/1ps
// Contract
// - all fragments of one packet carry the same fragment id
// - fragment id searched upward modulo eight from last start id plus one
// - no fragment id reused while its packet is still being fragmented
// - sequence permission set selects sequence byte, otherwise packet crc
// - eight sequence counters, one per fragment id, starting at zero
// - end fragment carries counter of its id, then counter increments mod 256
// - sequence mode clears the crc-usage flag of the start fragment
// - crc mode presets the 32-bit crc to all ones
// - crc fed protocol type, label, extensions, payload, bit order lsb first
// - final crc inverted and sent as four bytes, high byte first
// - no fragment label is emitted; its length is zero
// - explicit payload map uses one signalling byte per context; here one sigReg_q byte serves every context
// - burst label 0..15 bytes; strict mode uses fixed per-context sizes
// - no burst-level crc is appended here
// - on-board translation forces label type zero length six and crc; here only length six and crc are forced, labelType passes through unchanged
// - on-board translation never splits protocol type or crc; label kept whole only up to len0_q bytes
// - signalling traffic uses label type three, protocol type 0x0082
// - matching default protocol type is omitted and suppression flag set
// - packets over 4095 bytes are dropped
module rlf_fragmenter
	import rlf_pkg::*;
(
	input  wire logic        clock,
	input  wire logic        rst,
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output logic             hreadyout,
	output logic             hresp,
	output logic [31:0]      hrdata,
	input  wire logic [1:0]  accessCtx,
	input  wire logic        pktValid,
	input  wire rlf_hdr_t    pktHdr,
	output logic             pktReady,
	input  wire logic        inValid,
	input  wire logic [7:0]  inData,
	output logic             inReady,
	output logic             outValid,
	output logic [7:0]       outData,
	output rlf_info_t        outInfo,
	input  wire logic        outReady,
	output logic [7:0]       sigByte,
	output logic             sigEnable,
	output logic [3:0]       burstLabelLen,
	output logic [3:0]       fragLabelLen,
	output logic [3:0]       labelLen0
);

	// ----------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------
	function automatic logic [31:0] crcByte(input logic [31:0] c, input logic [7:0] b);
		logic [31:0] r;
		r = c;
		for (int i = 0; i < 8; i++)
		begin
			r = (r[31] ^ b[i]) ? ((r << 1) ^ CRC_POLY) : (r << 1);
		end
		return r;
	endfunction

	function automatic logic [2:0] pickFid(input logic [2:0] last, input logic [7:0] busy);
		logic [2:0] f;
		f = last;
		for (int i = 7; i >= 0; i--)
		begin
			if (!busy[3'(last + 3'(i + 1))])
				f = 3'(last + 3'(i + 1));
		end
		return f;
	endfunction

	// ----------------------------------------------------------------
	// registers
	// ----------------------------------------------------------------
	logic [5:0]  ctrl_q;
	logic [11:0] fragSize_q;
	logic [15:0] implPtype_q;
	logic [3:0]  len0_q;
	logic [3:0]  blbl_q;
	logic [7:0]  sigReg_q;
	logic [7:0]  dropCnt_q;
	logic        wrPend_q;
	logic [7:0]  wrAddr_q;

	rlf_state_t  state_q, state_d;
	rlf_hdr_t    hdr_q;
	logic [31:0] crc_q;
	logic [7:0]  seqCnt_q [8];
	logic [7:0]  fidBusy_q;
	logic [2:0]  lastFid_q, curFid_q;
	logic        frag_q, useCrc_q, supp_q;
	logic [1:0]  ltype_q;
	logic [12:0] total_q, outTotal_q, emitted_q, fragRem_q, bodyLeft_q;
	logic [1:0]  trailIdx_q;

	logic        seqMode, onboard, accept, emit, takeIn, tooBig, needFrag, suppress;
	logic [12:0] ptLen, tot, trailLen, remain, flen, trailStart;
	logic [7:0]  emitByte;
	logic [2:0]  fidPick;
	logic [1:0]  ltypeIn;
	logic        slotFree, outValid_d, lastByte;

	assign onboard  = ctrl_q[CTRL_ONBOARD];
	assign seqMode  = ctrl_q[CTRL_SEQ] && !onboard;
	assign ltypeIn  = pktHdr.isSignal ? LTYPE_SIGNAL : pktHdr.labelType;
	assign suppress = ctrl_q[CTRL_OMIT] && (pktHdr.isSignal ||
		(ltypeIn != LTYPE_SIGNAL && pktHdr.protoType == implPtype_q));
	assign ptLen    = suppress ? 13'h0000 : PTYPE_BYTES;
	assign tot      = pktHdr.pktLen + ptLen;
	assign tooBig   = tot > MAX_TOTAL;
	assign trailLen = seqMode ? SEQ_BYTES : CRC_BYTES;
	assign needFrag = (tot > 13'(fragSize_q));
	assign fidPick  = pickFid(lastFid_q, fidBusy_q);
	assign accept   = (state_q == ST_IDLE) && pktValid && pktReady &&
		(tooBig || !needFrag || fidBusy_q != 8'hff);
	assign slotFree = !outValid || outReady;
	assign takeIn   = inReady && inValid;

	// ----------------------------------------------------------------
	// fragment sizing
	// ----------------------------------------------------------------
	function automatic logic [12:0] ptLen_q();
		return supp_q ? 13'h0000 : PTYPE_BYTES;
	endfunction

	always_comb
	begin
		remain     = outTotal_q - emitted_q;
		flen       = (remain > 13'(fragSize_q)) ? 13'(fragSize_q) : remain;
		trailStart = outTotal_q - (frag_q ? (useCrc_q ? CRC_BYTES : SEQ_BYTES) : 13'h0000);
		if (onboard && frag_q)
		begin
			// keep header bytes together and the trailer whole
			if (emitted_q == 13'h0000 && flen < 13'(ptLen_q() + 13'(len0_q)))
				flen = 13'(ptLen_q() + 13'(len0_q));
			if (emitted_q + flen > trailStart && emitted_q + flen < outTotal_q)
				flen = (trailStart > emitted_q) ? trailStart - emitted_q : remain;
		end
	end

	// ----------------------------------------------------------------
	// sequencing
	// ----------------------------------------------------------------
	always_comb
	begin
		state_d  = state_q;
		emit     = 1'b0;
		emitByte = 8'h00;
		case (state_q)
			ST_IDLE:
			begin
				if (accept)
					state_d = tooBig ? ST_DROP : (suppress ? ST_BODY : ST_PT0);
			end
			ST_PT0:
			begin
				emit     = slotFree;
				emitByte = hdr_q.protoType[15:8];
				if (emit)
					state_d = ST_PT1;
			end
			ST_PT1:
			begin
				emit     = slotFree;
				emitByte = hdr_q.protoType[7:0];
				if (emit)
					state_d = (hdr_q.pktLen == 13'h0000) ? (frag_q ? ST_TRAIL : ST_IDLE) : ST_BODY;
			end
			ST_BODY:
			begin
				emit     = takeIn;
				emitByte = inData;
				if (emit && bodyLeft_q == 13'h0001)
					state_d = frag_q ? ST_TRAIL : ST_IDLE;
			end
			ST_TRAIL:
			begin
				emit = slotFree;
				if (!useCrc_q)
					emitByte = seqCnt_q[curFid_q];
				else
					emitByte = ~crc_q[8'(31 - 8 * trailIdx_q) -: 8];
				if (emit && (!useCrc_q || trailIdx_q == 2'h3))
					state_d = ST_IDLE;
			end
			ST_DROP:
			begin
				if (takeIn && bodyLeft_q <= 13'h0001)
					state_d = ST_IDLE;
			end
			default:
				state_d = ST_IDLE;
		endcase
	end

	assign lastByte   = emit && (emitted_q + 13'h0001 == outTotal_q);
	assign outValid_d = emit || (outValid && !outReady);

	always_ff @(posedge clock)
	begin
		if (rst)
			state_q <= ST_IDLE;
		else
			state_q <= state_d;
	end

	always_ff @(posedge clock)
	begin
		if (rst)
		begin
			pktReady <= 1'b0;
			inReady  <= 1'b0;
		end
		else
		begin
			pktReady <= (state_d == ST_IDLE) && !accept;
			// one byte in flight: halves throughput but keeps ready a flop
			inReady  <= state_d == ST_DROP ||
				(state_d == ST_BODY && !outValid_d && !takeIn);
		end
	end

	always_ff @(posedge clock)
	begin
		if (rst)
		begin
			hdr_q      <= '0;
			frag_q     <= 1'b0;
			useCrc_q   <= 1'b0;
			supp_q     <= 1'b0;
			ltype_q    <= 2'h0;
			total_q    <= 13'h0000;
			outTotal_q <= 13'h0000;
			bodyLeft_q <= 13'h0000;
			curFid_q   <= 3'h0;
			lastFid_q  <= 3'h7;
			dropCnt_q  <= 8'h00;
		end
		else if (accept)
		begin
			hdr_q      <= pktHdr;
			hdr_q.protoType <= pktHdr.isSignal ? PTYPE_SIGNAL : pktHdr.protoType;
			frag_q     <= needFrag && !tooBig;
			useCrc_q   <= !seqMode;
			supp_q     <= suppress;
			ltype_q    <= ltypeIn;
			total_q    <= tot;
			outTotal_q <= tot + ((needFrag && !tooBig) ? trailLen : 13'h0000);
			bodyLeft_q <= pktHdr.pktLen;
			if (tooBig)
				dropCnt_q <= dropCnt_q + 8'h01;
			if (needFrag && !tooBig)
			begin
				curFid_q  <= fidPick;
				lastFid_q <= fidPick;
			end
		end
		else if (takeIn)
			bodyLeft_q <= bodyLeft_q - 13'h0001;
	end

	always_ff @(posedge clock)
	begin
		if (rst)
			fidBusy_q <= 8'h00;
		else if (accept && needFrag && !tooBig)
			fidBusy_q[fidPick] <= 1'b1;
		else if (lastByte && frag_q)
			fidBusy_q[curFid_q] <= 1'b0;
	end

	always_ff @(posedge clock)
	begin
		if (rst)
		begin
			for (int i = 0; i < 8; i++)
				seqCnt_q[i] <= 8'h00;
		end
		else if (emit && state_q == ST_TRAIL && !useCrc_q)
			seqCnt_q[curFid_q] <= seqCnt_q[curFid_q] + 8'h01;
	end

	always_ff @(posedge clock)
	begin
		if (rst)
		begin
			crc_q      <= CRC_ONES;
			trailIdx_q <= 2'h0;
		end
		else if (accept)
		begin
			// original two-byte type is always covered, even when omitted
			crc_q      <= crcByte(crcByte(CRC_ONES, pktHdr.isSignal ? PTYPE_SIGNAL[15:8] :
				pktHdr.protoType[15:8]), pktHdr.isSignal ? PTYPE_SIGNAL[7:0] :
				pktHdr.protoType[7:0]);
			trailIdx_q <= 2'h0;
		end
		else if (emit && state_q == ST_BODY)
			crc_q <= crcByte(crc_q, emitByte);
		else if (emit && state_q == ST_TRAIL)
			trailIdx_q <= trailIdx_q + 2'h1;
	end

	// ----------------------------------------------------------------
	// output byte stream; no burst crc is added at this layer
	// ----------------------------------------------------------------
	always_ff @(posedge clock)
	begin
		if (rst)
		begin
			outValid  <= 1'b0;
			outData   <= 8'h00;
			outInfo   <= '0;
			emitted_q <= 13'h0000;
			fragRem_q <= 13'h0000;
		end
		else
		begin
			outValid <= outValid_d;
			if (accept)
			begin
				emitted_q <= 13'h0000;
				fragRem_q <= 13'h0000;
			end
			else if (emit)
			begin
				outData       <= emitByte;
				outInfo.sof   <= fragRem_q == 13'h0000;
				emitted_q     <= emitted_q + 13'h0001;
				if (fragRem_q == 13'h0000)
				begin
					fragRem_q         <= flen - 13'h0001;
					outInfo.startInd  <= emitted_q == 13'h0000;
					outInfo.endInd    <= flen == remain;
					outInfo.fragId    <= curFid_q;
					outInfo.useCrc    <= frag_q && useCrc_q;
					outInfo.ptypeSupp <= supp_q;
					outInfo.labelType <= ltype_q;
					outInfo.fragLen   <= flen;
					outInfo.totalLen  <= total_q;
				end
				else
					fragRem_q <= fragRem_q - 13'h0001;
			end
		end
	end

	// ----------------------------------------------------------------
	// context outputs; signalling byte, enable and burst label latched only between packets
	// ----------------------------------------------------------------
	always_ff @(posedge clock)
	begin
		if (rst)
		begin
			sigByte       <= SIG_RESET;
			sigEnable     <= 1'b0;
			burstLabelLen <= BLBL_RESET;
			fragLabelLen  <= FLBL_LEN;
			labelLen0     <= LEN0_RESET;
		end
		else
		begin
			fragLabelLen <= FLBL_LEN;
			labelLen0    <= onboard ? LEN0_ONBOARD : len0_q;
			if (state_q == ST_IDLE)
			begin
				sigByte   <= sigReg_q;
				sigEnable <= ctrl_q[CTRL_MAP];
				if (ctrl_q[CTRL_STRICT])
					burstLabelLen <= (accessCtx == 2'h0) ? BLBL_CTX0 :
						(accessCtx == 2'h1) ? BLBL_CTX1 : BLBL_CTX2;
				else
					burstLabelLen <= blbl_q;
			end
		end
	end

	// ----------------------------------------------------------------
	// bus slave, zero wait states
	// ----------------------------------------------------------------
	always_ff @(posedge clock)
	begin
		if (rst)
		begin
			hreadyout   <= 1'b1;
			hresp       <= 1'b0;
			hrdata      <= 32'h00000000;
			wrPend_q    <= 1'b0;
			wrAddr_q    <= 8'h00;
			ctrl_q      <= CTRL_RESET;
			fragSize_q  <= FRAG_RESET;
			implPtype_q <= PTYPE_RESET;
			len0_q      <= LEN0_RESET;
			blbl_q      <= BLBL_RESET;
			sigReg_q    <= SIG_RESET;
		end
		else
		begin
			wrPend_q <= hsel && htrans[1] && hready && hwrite;
			wrAddr_q <= haddr[7:0];
			if (wrPend_q)
			begin
				case (wrAddr_q)
					REG_CTRL:  ctrl_q <= hwdata[5:0];
					REG_FRAG:  fragSize_q <= hwdata[11:0];
					REG_LABEL:
					begin
						implPtype_q <= hwdata[31:16];
						blbl_q      <= hwdata[11:8];
						len0_q      <= hwdata[3:0];
					end
					REG_SIG:   sigReg_q <= hwdata[7:0];
					default:   ;
				endcase
			end
			if (hsel && htrans[1] && hready && !hwrite)
			begin
				case (haddr[7:0])
					REG_CTRL:   hrdata <= {26'h0000000, ctrl_q};
					REG_FRAG:   hrdata <= {20'h00000, fragSize_q};
					REG_LABEL:  hrdata <= {implPtype_q, 4'h0, blbl_q, 4'h0, len0_q};
					REG_SIG:    hrdata <= {24'h000000, sigReg_q};
					REG_STATUS: hrdata <= {dropCnt_q, 5'h00, lastFid_q, 5'h00,
						state_q, fidBusy_q};
					default:    hrdata <= 32'h00000000;
				endcase
			end
		end
	end

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	property p_sameFid;
		@(posedge clock) disable iff (rst)
		outValid && !outInfo.sof && $past(outValid) |-> outInfo.fragId == $past(outInfo.fragId);
	endproperty
	a_sameFid: assert property (p_sameFid) else $error("fragment id changed in packet");

	property p_fidSearch;
		@(posedge clock) disable iff (rst)
		accept && needFrag && !tooBig && fidBusy_q == 8'h00 |=> curFid_q == $past(lastFid_q) + 3'h1;
	endproperty
	a_fidSearch: assert property (p_fidSearch) else $error("fragment id not next in order");

	property p_noDup;
		@(posedge clock) disable iff (rst)
		accept && needFrag && !tooBig |-> !fidBusy_q[fidPick];
	endproperty
	a_noDup: assert property (p_noDup) else $error("busy fragment id reused");

	property p_seqInc;
		@(posedge clock) disable iff (rst)
		emit && state_q == ST_TRAIL && !useCrc_q |=> seqCnt_q[curFid_q] == $past(emitByte) + 8'h01;
	endproperty
	a_seqInc: assert property (p_seqInc) else $error("sequence counter did not advance");

	property p_useCrcFlag;
		@(posedge clock) disable iff (rst)
		outValid && outInfo.sof && outInfo.startInd && !outInfo.endInd && !useCrc_q
		|-> !outInfo.useCrc;
	endproperty
	a_useCrcFlag: assert property (p_useCrcFlag) else $error("crc flag set in sequence mode");

	property p_crcOut;
		@(posedge clock) disable iff (rst)
		emit && state_q == ST_TRAIL && useCrc_q && trailIdx_q == 2'h0 |=> outData == ~$past(crc_q[31:24]);
	endproperty
	a_crcOut: assert property (p_crcOut) else $error("crc high byte wrong");

	property p_drop;
		@(posedge clock) disable iff (rst)
		accept && tooBig && !outValid |=> state_q == ST_DROP && !outValid ##1 !outValid;
	endproperty
	a_drop: assert property (p_drop) else $error("oversize packet not dropped");

	property p_whole;
		@(posedge clock) disable iff (rst)
		outValid && outInfo.sof && !frag_q |-> outInfo.startInd && outInfo.endInd;
	endproperty
	a_whole: assert property (p_whole) else $error("unfragmented packet flags wrong");

endmodule

// >>> dv/rlf_hub_model.sv
`timescale 1ns/1ps
module rlf_hub_model
	import rlf_pkg::*;
(
	input  wire logic clock,
	input  wire logic rst,
	input  wire logic slow,
	output logic      outReady
);
	logic [1:0] stall_q;

	// ----------------------------------------------------------------
	// receiver stall
	// ----------------------------------------------------------------
	// slow mode takes one byte in four, so the sender must hold its bytes
	always_ff @(posedge clock)
	begin
		if (rst)
			stall_q <= 2'h0;
		else
			stall_q <= stall_q + 2'h1;
	end

	always_ff @(posedge clock)
	begin
		if (rst)
			outReady <= 1'b0;
		else
			outReady <= !slow || (stall_q == 2'h3);
	end
endmodule

// >>> dv/return_link_fragment_tx_tb_top.sv
`timescale 1ns/1ps
module return_link_fragment_tx_tb_top
	import rlf_pkg::*;
;
	logic        clock, rst, hwrite, pktValid, inValid, slow, hreadyout, hresp;
	logic        pktReady, inReady, outValid, outReady, sigEnable;
	logic [31:0] haddr, hwdata, hrdata, rd;
	logic [1:0]  htrans, accessCtx;
	logic [2:0]  hsize;
	logic [7:0]  inData, outData, sigByte;
	logic [3:0]  burstLabelLen, fragLabelLen, labelLen0;
	rlf_hdr_t    pktHdr;
	rlf_info_t   outInfo;
	rlf_info_t   infoQ[$];
	logic [7:0]  byteQ[$];
	int          errors, compares, expN;

	rlf_fragmenter uut (.clock(clock), .rst(rst), .hsel(1'b1), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
		.hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
		.accessCtx(accessCtx), .pktValid(pktValid), .pktHdr(pktHdr),
		.pktReady(pktReady), .inValid(inValid), .inData(inData), .inReady(inReady),
		.outValid(outValid), .outData(outData), .outInfo(outInfo),
		.outReady(outReady), .sigByte(sigByte), .sigEnable(sigEnable),
		.burstLabelLen(burstLabelLen), .fragLabelLen(fragLabelLen),
		.labelLen0(labelLen0));

	rlf_hub_model hub (.clock(clock), .rst(rst), .slow(slow), .outReady(outReady));

	initial clock = 1'b0;
	always #2 clock = ~clock;

	// ----------------------------------------------------------------
	// output capture
	// ----------------------------------------------------------------
	always @(posedge clock)
	begin
		if (outValid && outReady)
		begin
			byteQ.push_back(outData);
			if (outInfo.sof)
				infoQ.push_back(outInfo);
		end
	end

	// ----------------------------------------------------------------
	// tasks
	// ----------------------------------------------------------------
	task automatic report_and_stop;
		$display("compares=%0d errors=%0d", compares, errors);
		if (errors == 0 && compares > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp)
		begin
			errors++;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	// every wait is bounded; running out ends the run
	task automatic wait_hi(input int k);
		int n;
		n = 0;
		do
		begin
			@(posedge clock);
			n++;
			if (n > 300)
			begin
				errors++;
				$display("ERROR t=%0t timeout on wait %0d", $time, k);
				report_and_stop();
			end
		end
		while (!((k == 0 && hreadyout === 1'b1) || (k == 1 && pktReady === 1'b1)
			|| (k == 2 && inReady === 1'b1) || (k == 3 && byteQ.size() >= expN)));
	endtask

	task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
		htrans <= 2'h2;
		haddr <= {24'h0, a};
		hwrite <= wr;
		wait_hi(0);
		htrans <= 2'h0;
		hwdata <= d;
		wait_hi(0);
		rd = hrdata;
	endtask

	task automatic send(input int len, input logic [15:0] pt, input logic [1:0] lt,
		input logic sg, input int nb);
		byteQ.delete();
		infoQ.delete();
		pktValid <= 1'b1;
		pktHdr <= '{len[12:0], pt, lt, sg};
		wait_hi(1);
		pktValid <= 1'b0;
		for (int i = 0; i < len; i++)
		begin
			inValid <= 1'b1;
			inData <= 8'(i + 48);
			wait_hi(2);
		end
		inValid <= 1'b0;
		expN = nb;
		wait_hi(3);
	endtask

	task automatic frags(input int nb, input logic [2:0] fid, input logic crc);
		int nf;
		nf = (nb + 7) / 8;
		chk(32'(byteQ.size()), 32'(nb));
		chk(32'(infoQ.size()), 32'(nf));
		foreach (infoQ[k])
		begin
			chk(32'(infoQ[k].startInd), 32'(k == 0));
			chk(32'(infoQ[k].endInd), 32'(k == nf - 1));
			if (nf > 1)
			begin
				chk(32'(infoQ[k].fragId), 32'(fid));
				chk(32'(infoQ[k].useCrc), 32'(crc));
			end
		end
	endtask

	// bits enter lsb first, the original protocol type ahead of the body
	function automatic logic [31:0] crc_of(input logic [15:0] pt, input int len);
		logic [31:0] c;
		logic [7:0]  b;
		c = CRC_ONES;
		for (int i = -2; i < len; i++)
		begin
			b = (i == -2) ? pt[15:8] : (i == -1) ? pt[7:0] : 8'(i + 48);
			for (int j = 0; j < 8; j++)
				c = {c[30:0], 1'b0} ^ ((c[31] ^ b[j]) ? CRC_POLY : 32'h0);
		end
		return ~c;
	endfunction

	// ----------------------------------------------------------------
	// main sequence
	// ----------------------------------------------------------------
	initial
	begin
		errors = 0;
		compares = 0;
		expN = 0;
		rst = 1'b1;
		{hwrite, pktValid, inValid, slow} = 4'h0;
		htrans = 2'h0;
		accessCtx = 2'h0;
		hsize = 3'h2;
		haddr = 32'h0;
		hwdata = 32'h0;
		inData = 8'h0;
		pktHdr = '0;
		repeat (10) @(posedge clock);
		rst <= 1'b0;
		repeat (2) @(posedge clock);
		bus(0, REG_CTRL, 32'h0);
		chk(rd, 32'h01);
		bus(0, REG_FRAG, 32'h0);
		chk(rd, 32'h40);
		bus(0, REG_LABEL, 32'h0);
		chk(rd, 32'h08000001);
		bus(0, REG_STATUS, 32'h0);
		chk(rd, 32'h00070000);
		bus(1, 8'h14, 32'hffffffff);
		bus(0, 8'h14, 32'h0);
		chk(rd, 32'h0);
		chk(32'(hresp), 32'h0);
		chk(32'(hreadyout), 32'h1);
		chk(32'(fragLabelLen), 32'h0);
		$display("test registers done");
		bus(1, REG_FRAG, 32'h8);
		for (int p = 0; p < 9; p++)
		begin
			send(12, 16'h0800, 2'h0, 1'b0, 15);
			frags(15, 3'(p % 8), 1'b0);
			chk({24'h0, byteQ[0]}, 32'h08);
			chk({24'h0, byteQ[14]}, 32'(p / 8));
		end
		send(3, 16'h0800, 2'h0, 1'b0, 5);
		frags(5, 3'h0, 1'b0);
		$display("test sequence done");
		bus(1, REG_CTRL, 32'h2);
		slow <= 1'b1;
		send(12, 16'h0800, 2'h0, 1'b0, 18);
		slow <= 1'b0;
		frags(18, 3'h1, 1'b1);
		chk({byteQ[14], byteQ[15], byteQ[16], byteQ[17]}, crc_of(16'h0800, 12));
		$display("test crc done");
		bus(1, REG_CTRL, 32'h5);
		send(2, PTYPE_SIGNAL, LTYPE_SIGNAL, 1'b1, 2);
		frags(2, 3'h0, 1'b0);
		chk(32'(infoQ[0].ptypeSupp), 32'h1);
		chk(32'(infoQ[0].labelType), 32'h3);
		chk({24'h0, byteQ[0]}, 32'h30);
		$display("test signalling done");
		bus(1, REG_CTRL, 32'h1);
		send(4094, 16'h0800, 2'h0, 1'b0, 0);
		chk(32'(byteQ.size()), 32'h0);
		bus(0, REG_STATUS, 32'h0);
		chk({24'h0, rd[31:24]}, 32'h1);
		$display("test drop done");
		accessCtx <= 2'h1;
		bus(1, REG_SIG, 32'ha5);
		bus(1, REG_CTRL, 32'h3a);
		bus(0, REG_CTRL, 32'h0);
		chk(rd, 32'h3a);
		chk(32'(labelLen0), 32'h6);
		chk(32'(burstLabelLen), 32'h6);
		chk({23'h0, sigEnable, sigByte}, 32'h1a5);
		send(12, 16'h0800, 2'h0, 1'b0, 18);
		frags(18, 3'h2, 1'b1);
		chk(32'(infoQ[1].fragLen), 32'h6);
		chk(32'(infoQ[2].fragLen), 32'h4);
		chk(32'(infoQ[0].totalLen), 32'he);
		chk({byteQ[14], byteQ[15], byteQ[16], byteQ[17]}, crc_of(16'h0800, 12));
		accessCtx <= 2'h0;
		bus(0, REG_SIG, 32'h0);
		chk(rd, 32'ha5);
		chk(32'(burstLabelLen), 32'h0);
		bus(1, REG_CTRL, 32'h1);
		bus(1, REG_LABEL, 32'h08000f01);
		bus(0, REG_LABEL, 32'h0);
		chk(rd, 32'h08000f01);
		chk(32'(burstLabelLen), 32'hf);
		chk(32'(sigEnable), 32'h0);
		chk(32'(labelLen0), 32'h1);
		$display("test levels done");
		report_and_stop();
	end
endmodule
